// *** dma_cmd_pkg.sv ***
// package: register map, command codes, field layouts for the dma command block
package dma_cmd_pkg;

	// ==========================================================
	// register map (byte addresses)
	localparam logic [7:0] ADDR_DMA_COMMAND = 8'h30;
	localparam logic [7:0] ADDR_TASK_INDEX = 8'h38;
	localparam logic [7:0] ADDR_ENDPOINT_INDEX = 8'h3C;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h40;
	localparam logic [7:0] ADDR_INT_MASK = 8'h44;
	localparam logic [7:0] ADDR_DMA_STATE = 8'h48;

	// ==========================================================
	// reset values and read answers
	localparam logic [7:0] DMA_COMMAND_RESET = 8'hFF;
	localparam logic [7:0] DMA_COMMAND_READ = 8'hFF;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// ==========================================================
	// command codes
	localparam logic [7:0] CMD_GENERIC_SLAVE_DMA_IN = 8'h00;
	localparam logic [7:0] CMD_GENERIC_SLAVE_DMA_OUT = 8'h01;
	localparam logic [7:0] CMD_MULTIWORD_DMA_IN = 8'h06;
	localparam logic [7:0] CMD_MULTIWORD_DMA_OUT = 8'h07;
	localparam logic [7:0] CMD_READ_DATA = 8'h0A;
	localparam logic [7:0] CMD_POLL_BUSY = 8'h0B;
	localparam logic [7:0] CMD_READ_TASKS = 8'h0C;
	localparam logic [7:0] CMD_VALIDATE = 8'h0E;
	localparam logic [7:0] CMD_CLEAR_BUF = 8'h0F;
	localparam logic [7:0] CMD_RESTART = 8'h10;

	// ==========================================================
	// task-file addresses (low 4 bits of 1Fxh)
	localparam logic [3:0] TF_DATA = 4'h0;
	localparam logic [3:0] TF_FIRST = 4'h1;
	localparam logic [3:0] TF_LAST = 4'h6;
	localparam logic [3:0] TF_STATUS = 4'h7;
	localparam int BUSY_BIT = 7;

	// ==========================================================
	// interrupt status bit positions
	localparam int INT_POLL_DONE = 0;
	localparam int INT_TASKS_DONE = 1;
	localparam int INT_DATA_DONE = 2;
	localparam int INT_WIDTH = 3;

	// ==========================================================
	// dma mode seen by the transfer engine
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_GENERIC_SLAVE_DMA_IN,
		MODE_GENERIC_SLAVE_DMA_OUT,
		MODE_MULTIWORD_DMA_IN,
		MODE_MULTIWORD_DMA_OUT
	} dma_mode_t;

	// pio request toward the task-file port, always one 16-bit word
	typedef struct packed {
		logic valid;
		logic [3:0] addr;
	} pio_req_t;

	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} pio_rsp_t;

	// endpoint buffer action pulses
	typedef struct packed {
		logic validate;
		logic clear_tx;
		logic restart;
		logic [3:0] index;
	} ep_action_t;

endpackage

// *** dma_command_dispatch.sv ***
// dma command register, decoder and pio sequencer with avalon-mm slave
//
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps

//
// Contract
// - command register is one write-only byte; reads return FFh
// - dma data bus undriven from reset until first transfer command (00h, 01h, 06h, 07h) executes
// - every pio cycle from a command moves exactly one 16-bit word
// - 00h starts slave generic dma in, external write strobe per word
// - 01h starts slave generic dma out, external read strobe per word
// - 06h starts multiword dma in; 07h multiword dma out
// - 0Ah starts a single pio read of the data register 1F0h
// - 0Bh polls status until busy clear, then stops; irq when unmasked
// - masked poll-done interrupt still sets its status bit
// - 0Ch with index zero reads all task registers except 1F0h, 1F7h
// - 0Ch with nonzero index reads only the selected task register
// - task read done sets status even if masked; irq when unmasked
// - 0Eh validates indexed endpoint buffer after ata-to-usb transfer
// - 0Fh clears indexed endpoint tx buffer, rx untouched
// - tx buffer clears itself once sent; 0Fh only forces it
// - 10h resets indexed endpoint buffer pointers to fifo start
module dma_command_dispatch #(
	parameter int TF_DEPTH = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	// avalon-mm slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// transfer engine
	output dma_cmd_pkg::dma_mode_t o_dma_mode,
	output logic o_dma_start,
	output logic o_dma_bus_oe_n,
	// task-file pio port
	output dma_cmd_pkg::pio_req_t o_pio_req,
	input wire dma_cmd_pkg::pio_rsp_t i_pio_rsp,
	// endpoint buffers
	output dma_cmd_pkg::ep_action_t o_ep_action,
	output logic o_irq
);

	// ==========================================================
	// bus decode
	typedef enum {
		BUS_IDLE,
		BUS_WAIT,
		BUS_DONE
	} bus_state_t;

	bus_state_t bus_state;
	bus_state_t next_bus_state;
	logic [7:0] addr;
	logic is_write;
	logic [31:0] wdata;
	logic [3:0] bena;

	wire req = i_avs_read | i_avs_write;
	wire hit_cmd = addr == dma_cmd_pkg::ADDR_DMA_COMMAND;
	wire hit_task = addr == dma_cmd_pkg::ADDR_TASK_INDEX;
	wire hit_ep = addr == dma_cmd_pkg::ADDR_ENDPOINT_INDEX;
	wire hit_stat = addr == dma_cmd_pkg::ADDR_INT_STATUS;
	wire hit_mask = addr == dma_cmd_pkg::ADDR_INT_MASK;
	wire hit_state = addr == dma_cmd_pkg::ADDR_DMA_STATE;
	// access commits in the cycle waitrequest is low
	wire commit = bus_state == BUS_DONE;
	wire wr_commit = commit & is_write & bena[0];
	// read data is latched one cycle early so it stands while waitrequest is low
	wire rd_commit = (bus_state == BUS_WAIT) & !is_write;
	wire cmd_wr = wr_commit & hit_cmd;

	always_comb begin
		next_bus_state = bus_state;
		unique case (bus_state)
			BUS_IDLE: if (req) next_bus_state = BUS_WAIT;
			BUS_WAIT: next_bus_state = BUS_DONE;
			BUS_DONE: next_bus_state = BUS_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			bus_state <= BUS_IDLE;
			addr <= '0;
			is_write <= 1'b0;
			wdata <= '0;
			bena <= '0;
		end else begin
			bus_state <= next_bus_state;
			if (bus_state == BUS_IDLE && req) begin
				addr <= i_avs_address;
				is_write <= i_avs_write;
				wdata <= i_avs_writedata;
				bena <= i_avs_byteenable;
			end
		end
	end

	// ==========================================================
	// software registers
	logic [7:0] dma_command;
	logic [3:0] task_index;
	logic [3:0] ep_index;
	logic [dma_cmd_pkg::INT_WIDTH-1:0] int_status;
	logic [dma_cmd_pkg::INT_WIDTH-1:0] int_mask;
	logic [dma_cmd_pkg::INT_WIDTH-1:0] int_event;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			task_index <= '0;
			ep_index <= '0;
			int_mask <= '0;
		end else begin
			if (wr_commit && hit_task) task_index <= wdata[3:0];
			if (wr_commit && hit_ep) ep_index <= wdata[3:0];
			if (wr_commit && hit_mask) begin
				int_mask <= wdata[dma_cmd_pkg::INT_WIDTH-1:0];
			end
		end
	end

	// status is set regardless of mask; new events win over read clear
	wire stat_rd = rd_commit & hit_stat;
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			int_status <= '0;
		end else begin
			int_status <= (stat_rd ? '0 : int_status) | int_event;
		end
	end

	// ==========================================================
	// command decode
	wire [7:0] code = wdata[7:0];
	wire is_generic_slave_dma_in = code == dma_cmd_pkg::CMD_GENERIC_SLAVE_DMA_IN;
	wire is_generic_slave_dma_out = code == dma_cmd_pkg::CMD_GENERIC_SLAVE_DMA_OUT;
	wire is_multiword_dma_in = code == dma_cmd_pkg::CMD_MULTIWORD_DMA_IN;
	wire is_multiword_dma_out = code == dma_cmd_pkg::CMD_MULTIWORD_DMA_OUT;
	wire is_dma = is_generic_slave_dma_in | is_generic_slave_dma_out | is_multiword_dma_in | is_multiword_dma_out;
	wire is_rd_data = code == dma_cmd_pkg::CMD_READ_DATA;
	wire is_poll = code == dma_cmd_pkg::CMD_POLL_BUSY;
	wire is_tasks = code == dma_cmd_pkg::CMD_READ_TASKS;
	wire is_pio = is_rd_data | is_poll | is_tasks;
	wire is_valid = code == dma_cmd_pkg::CMD_VALIDATE;
	wire is_clear = code == dma_cmd_pkg::CMD_CLEAR_BUF;
	wire is_restart = code == dma_cmd_pkg::CMD_RESTART;
	wire is_known = is_dma | is_pio | is_valid | is_clear | is_restart;

	dma_cmd_pkg::dma_mode_t next_mode;
	always_comb begin
		next_mode = o_dma_mode;
		if (cmd_wr && is_generic_slave_dma_in) next_mode = dma_cmd_pkg::MODE_GENERIC_SLAVE_DMA_IN;
		if (cmd_wr && is_generic_slave_dma_out) next_mode = dma_cmd_pkg::MODE_GENERIC_SLAVE_DMA_OUT;
		if (cmd_wr && is_multiword_dma_in) next_mode = dma_cmd_pkg::MODE_MULTIWORD_DMA_IN;
		if (cmd_wr && is_multiword_dma_out) next_mode = dma_cmd_pkg::MODE_MULTIWORD_DMA_OUT;
	end

	// last accepted code; reserved codes leave it alone
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dma_command <= dma_cmd_pkg::DMA_COMMAND_RESET;
		end else if (cmd_wr && is_known) begin
			dma_command <= code;
		end
	end

	// ==========================================================
	// pio sequencer
	typedef enum {
		PIO_IDLE,
		PIO_ISSUE,
		PIO_WAIT
	} pio_state_t;

	typedef enum {
		JOB_DATA,
		JOB_POLL,
		JOB_TASKS
	} pio_job_t;

	pio_state_t pio_state;
	pio_job_t pio_job;
	logic [3:0] pio_addr;
	logic tasks_all;

	wire pio_start = cmd_wr & is_pio & (pio_state == PIO_IDLE);
	wire rsp = (pio_state == PIO_WAIT) & i_pio_rsp.valid;
	wire busy_clear = !i_pio_rsp.data[dma_cmd_pkg::BUSY_BIT];
	wire poll_done = rsp & (pio_job == JOB_POLL) & busy_clear;
	wire tasks_last = !tasks_all | (pio_addr == dma_cmd_pkg::TF_LAST);
	wire tasks_done = rsp & (pio_job == JOB_TASKS) & tasks_last;
	wire data_done = rsp & (pio_job == JOB_DATA);
	wire pio_end = poll_done | tasks_done | data_done;
	wire start_idx0 = task_index == '0;
	wire [3:0] first_addr = is_rd_data ? dma_cmd_pkg::TF_DATA :
		is_poll ? dma_cmd_pkg::TF_STATUS :
		start_idx0 ? dma_cmd_pkg::TF_FIRST : task_index;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pio_state <= PIO_IDLE;
			pio_job <= JOB_DATA;
			pio_addr <= '0;
			tasks_all <= 1'b0;
		end else begin
			unique case (pio_state)
				PIO_IDLE: if (pio_start) begin
					pio_state <= PIO_ISSUE;
					pio_addr <= first_addr;
					tasks_all <= start_idx0;
					pio_job <= is_rd_data ? JOB_DATA :
						is_poll ? JOB_POLL : JOB_TASKS;
				end
				PIO_ISSUE: pio_state <= PIO_WAIT;
				PIO_WAIT: if (rsp) begin
					// busy still set: reissue the same status read
					pio_state <= pio_end ? PIO_IDLE : PIO_ISSUE;
					if (pio_job == JOB_TASKS && !tasks_last) begin
						pio_addr <= pio_addr + 4'h1;
					end
				end
			endcase
		end
	end

	always_comb begin
		int_event = '0;
		int_event[dma_cmd_pkg::INT_POLL_DONE] = poll_done;
		int_event[dma_cmd_pkg::INT_TASKS_DONE] = tasks_done;
		int_event[dma_cmd_pkg::INT_DATA_DONE] = data_done;
	end

	// ==========================================================
	// task-file words kept for software
	logic [15:0] tf_word;

	task_file_store #(
		.DEPTH(TF_DEPTH),
		.WIDTH(16)
	) task_file_store_inst (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_wr_en(rsp),
		.i_wr_addr(pio_addr),
		.i_wr_data(i_pio_rsp.data),
		.i_rd_addr(task_index),
		.o_rd_data(tf_word)
	);

	// ==========================================================
	// register read-back
	// the command byte is write-only; its address always answers FFh
	wire [31:0] cmd_rd = {24'h000000, dma_cmd_pkg::DMA_COMMAND_READ};
	wire [31:0] state_rd = {5'h00, tf_word, dma_command, o_dma_mode};
	wire [31:0] rd_value =
		hit_cmd ? cmd_rd :
		hit_task ? {28'h0000000, task_index} :
		hit_ep ? {28'h0000000, ep_index} :
		hit_stat ? {29'h00000000, int_status} :
		hit_mask ? {29'h00000000, int_mask} :
		hit_state ? state_rd : dma_cmd_pkg::UNMAPPED_READ;

	// waitrequest drops only in the cycle the access commits
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= '0;
		end else begin
			o_avs_waitrequest <= next_bus_state != BUS_DONE;
			if (rd_commit) o_avs_readdata <= rd_value;
		end
	end

	// ==========================================================
	// engine, pio and endpoint outputs
	wire dma_go = cmd_wr & is_dma;

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_dma_mode <= dma_cmd_pkg::MODE_IDLE;
			o_dma_start <= 1'b0;
			o_dma_bus_oe_n <= 1'b1;
			o_pio_req <= '0;
			o_ep_action <= '0;
			o_irq <= 1'b0;
		end else begin
			o_dma_mode <= next_mode;
			o_dma_start <= dma_go;
			// bus stays released until a transfer command runs
			if (dma_go) o_dma_bus_oe_n <= 1'b0;
			// one request per issue state: a single word each time
			o_pio_req.valid <= pio_state == PIO_ISSUE;
			o_pio_req.addr <= pio_addr;
			o_ep_action.validate <= cmd_wr & is_valid;
			// buffer clears itself after sending; this only forces it
			o_ep_action.clear_tx <= cmd_wr & is_clear;
			o_ep_action.restart <= cmd_wr & is_restart;
			o_ep_action.index <= ep_index;
			o_irq <= |(int_status & int_mask);
		end
	end

	// ==========================================================
	// assertions
	property p_cmd_reads_ff;
		@(posedge i_clk) disable iff (!i_rst_n)
		(rd_commit && hit_cmd) |=> o_avs_readdata == 32'h000000FF;
	endproperty
	a_cmd_reads_ff: assert property (p_cmd_reads_ff)
		else $error("command address read did not return FFh");

	property p_bus_released;
		@(posedge i_clk) disable iff (!i_rst_n)
		(o_dma_bus_oe_n && !dma_go) |=> o_dma_bus_oe_n;
	endproperty
	a_bus_released: assert property (p_bus_released)
		else $error("dma bus driven before a transfer command");

	property p_one_word;
		@(posedge i_clk) disable iff (!i_rst_n)
		o_pio_req.valid |=> !o_pio_req.valid;
	endproperty
	a_one_word: assert property (p_one_word)
		else $error("pio request held for more than one word");

	property p_reserved_inert;
		@(posedge i_clk) disable iff (!i_rst_n)
		(cmd_wr && !is_known) |=>
			(!o_dma_start && o_dma_mode == $past(o_dma_mode));
	endproperty
	a_reserved_inert: assert property (p_reserved_inert)
		else $error("reserved code changed the dma state");

	property p_poll_sets;
		@(posedge i_clk) disable iff (!i_rst_n)
		poll_done |=> int_status[dma_cmd_pkg::INT_POLL_DONE];
	endproperty
	a_poll_sets: assert property (p_poll_sets)
		else $error("poll completion did not set its status bit");

	property p_tasks_sets;
		@(posedge i_clk) disable iff (!i_rst_n)
		tasks_done |=> int_status[dma_cmd_pkg::INT_TASKS_DONE];
	endproperty
	a_tasks_sets: assert property (p_tasks_sets)
		else $error("task read completion did not set its status bit");

	property p_clear_only_tx;
		@(posedge i_clk) disable iff (!i_rst_n)
		(cmd_wr && is_clear) |=>
			(o_ep_action.clear_tx && !o_ep_action.restart);
	endproperty
	a_clear_only_tx: assert property (p_clear_only_tx)
		else $error("clear command did not pulse only the tx clear");

endmodule

// *** dma_command_dispatch_tb.sv ***
// self-checking testbench for the dma command block
`timescale 1ns/1ps

module dma_command_dispatch_tb;
	// ==========================================================
	// signals and instances
	logic clk;
	logic rst_n;
	logic [7:0] adr;
	logic rd;
	logic wr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic waitreq;
	dma_cmd_pkg::dma_mode_t mode;
	logic start;
	logic oe_n;
	dma_cmd_pkg::pio_req_t req;
	dma_cmd_pkg::pio_rsp_t rsp;
	dma_cmd_pkg::ep_action_t ep;
	logic irq;
	int err_count;
	int check_count;
	int start_cnt;
	logic [2:0] ep_seen;
	logic [3:0] ep_idx;
	logic [31:0] v;
	logic [7:0] codes[4];
	dma_cmd_pkg::dma_mode_t modes[4];

	dma_command_dispatch dma_command_dispatch_inst (
		.i_clk(clk), .i_rst_n(rst_n), .i_avs_address(adr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
		.i_avs_byteenable(4'hF), .o_avs_readdata(rdata),
		.o_avs_waitrequest(waitreq), .o_dma_mode(mode),
		.o_dma_start(start), .o_dma_bus_oe_n(oe_n), .o_pio_req(req),
		.i_pio_rsp(rsp), .o_ep_action(ep), .o_irq(irq));
	pio_device_model pio_device_model_inst (
		.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .o_rsp(rsp));

	// ==========================================================
	// clock, monitors, watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) begin
		if (start === 1'b1) start_cnt <= start_cnt + 1;
		if (ep.validate || ep.clear_tx || ep.restart) begin
			ep_seen <= ep_seen | {ep.validate, ep.clear_tx, ep.restart};
			ep_idx <= ep.index;
		end
	end
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		wrap_up();
	end

	// ==========================================================
	// bus tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic av_cycle(input logic [7:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 100);
		if (n >= 100) err_count++;
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic av_write(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		av_cycle(a, 1'b1, d, q);
	endtask
	task automatic wait_status(input int b);
		int n;
		n = 0;
		v = '0;
		while (v[b] !== 1'b1 && n < 50) begin
			av_cycle(dma_cmd_pkg::ADDR_INT_STATUS, 1'b0, '0, v);
			n++;
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ==========================================================
	// test sequence
	initial begin
		{rst_n, rd, wr, adr, wdata, start_cnt, ep_seen, ep_idx} = '0;
		codes = '{8'h00, 8'h01, 8'h06, 8'h07};
		modes = '{dma_cmd_pkg::MODE_GENERIC_SLAVE_DMA_IN, dma_cmd_pkg::MODE_GENERIC_SLAVE_DMA_OUT,
			dma_cmd_pkg::MODE_MULTIWORD_DMA_IN, dma_cmd_pkg::MODE_MULTIWORD_DMA_OUT};
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		check(oe_n, 1'b1);
		av_cycle(dma_cmd_pkg::ADDR_DMA_COMMAND, 1'b0, '0, v);
		check(v[7:0], 8'hFF);
		av_cycle(8'h50, 1'b0, '0, v);
		check(v, dma_cmd_pkg::UNMAPPED_READ);
		foreach (codes[i]) begin
			av_write(dma_cmd_pkg::ADDR_DMA_COMMAND, 32'(i + 2));
			av_write(dma_cmd_pkg::ADDR_DMA_COMMAND, 32'h0D);
		end
		repeat (3) @(posedge clk);
		check({start_cnt[7:0], oe_n}, 9'h001);
		av_write(dma_cmd_pkg::ADDR_INT_MASK, 32'h0);
		av_write(dma_cmd_pkg::ADDR_DMA_COMMAND, 32'h0B);
		wait_status(dma_cmd_pkg::INT_POLL_DONE);
		check({irq, v[0]}, 2'b01);
		check(32'(pio_device_model_inst.polls), 32'h3);
		pio_device_model_inst.seen.delete();
		av_write(dma_cmd_pkg::ADDR_TASK_INDEX, 32'h0);
		av_write(dma_cmd_pkg::ADDR_DMA_COMMAND, 32'h0C);
		wait_status(dma_cmd_pkg::INT_TASKS_DONE);
		check({irq, v[1]}, 2'b01);
		check(32'(pio_device_model_inst.seen.size()), 32'h6);
		foreach (pio_device_model_inst.seen[i])
			check(pio_device_model_inst.seen[i], 4'(i + 1));
		pio_device_model_inst.seen.delete();
		av_write(dma_cmd_pkg::ADDR_INT_MASK, 32'h2);
		av_write(dma_cmd_pkg::ADDR_TASK_INDEX, 32'h3);
		av_write(dma_cmd_pkg::ADDR_DMA_COMMAND, 32'h0C);
		for (int n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk);
		check(irq, 1'b1);
		check(pio_device_model_inst.seen[0], 4'h3);
		check(32'(pio_device_model_inst.seen.size()), 32'h1);
		wait_status(dma_cmd_pkg::INT_TASKS_DONE);
		repeat (2) @(posedge clk);
		check(irq, 1'b0);
		av_write(dma_cmd_pkg::ADDR_ENDPOINT_INDEX, 32'h5);
		for (int k = 0; k < 3; k++) begin
			ep_seen <= '0;
			av_write(dma_cmd_pkg::ADDR_DMA_COMMAND, 32'(8'h0E + k));
			repeat (3) @(posedge clk);
			check({ep_seen, ep_idx}, {3'(3'b100 >> k), 4'h5});
		end
		ep_seen <= '0;
		repeat (2) av_write(dma_cmd_pkg::ADDR_DMA_COMMAND, 32'h0F);
		repeat (3) @(posedge clk);
		check({ep_seen, ep_idx}, {3'b010, 4'h5});
		pio_device_model_inst.seen.delete();
		av_write(dma_cmd_pkg::ADDR_DMA_COMMAND, 32'h0A);
		repeat (20) @(posedge clk);
		check(pio_device_model_inst.seen[0], dma_cmd_pkg::TF_DATA);
		foreach (codes[i]) begin
			av_write(dma_cmd_pkg::ADDR_DMA_COMMAND, 32'(codes[i]));
			repeat (3) @(posedge clk);
			check(mode, modes[i]);
			check(oe_n, 1'b0);
			check(start_cnt, i + 1);
		end
		wrap_up();
	end
endmodule

// *** pio_device_model.sv ***
// far-side task-file device model answering single-word pio reads
`timescale 1ns/1ps

module pio_device_model #(
	parameter int BUSY_POLLS = 3
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire dma_cmd_pkg::pio_req_t i_req,
	output dma_cmd_pkg::pio_rsp_t o_rsp
);
	// ==========================================================
	// request capture and delayed answer
	logic [3:0] seen[$];
	int polls;
	int wait_cnt;
	logic [3:0] addr;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rsp <= '0;
			polls <= 0;
			wait_cnt <= 0;
			addr <= '0;
		end else begin
			o_rsp.valid <= 1'b0;
			// released lines must not keep showing the last word
			o_rsp.data <= ~o_rsp.data;
			if (wait_cnt > 0) begin
				wait_cnt <= wait_cnt - 1;
				if (wait_cnt == 1) begin
					o_rsp.valid <= 1'b1;
					if (addr == dma_cmd_pkg::TF_STATUS) begin
						o_rsp.data <= {8'h00, polls < BUSY_POLLS, 7'h00};
					end else begin
						o_rsp.data <= {12'hA5C, addr};
					end
				end
			end else if (i_req.valid && !o_rsp.valid) begin
				addr <= i_req.addr;
				seen.push_back(i_req.addr);
				wait_cnt <= 2;
				if (i_req.addr == dma_cmd_pkg::TF_STATUS) begin
					polls <= polls + 1;
				end
			end
		end
	end
endmodule

// *** task_file_store.sv ***
// small register memory holding the words read back from the task file
`timescale 1ns/1ps

module task_file_store #(
	parameter int DEPTH = 16,
	parameter int WIDTH = 16
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_wr_en,
	input wire logic [$clog2(DEPTH)-1:0] i_wr_addr,
	input wire logic [WIDTH-1:0] i_wr_data,
	input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
	output logic [WIDTH-1:0] o_rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
	end

	// read data registered so the bus answer is a flop
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_rd_data <= '0;
		end else begin
			o_rd_data <= mem[i_rd_addr];
		end
	end

endmodule
